// File: design/pmc_pkg.sv
// package for the periodic match counter: register map, fields, constants
package pmc_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] PMC_OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] PMC_OFS_COUNT_VALUE = 8'h04;
    localparam logic [7:0] PMC_OFS_MATCH_LIMIT = 8'h08;
    localparam logic [7:0] PMC_OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] PMC_OFS_IRQ_MASK = 8'h10;
    // status_control field positions
    localparam int PMC_BIT_FLAG = 7;
    localparam int PMC_BIT_SRC_HI = 6;
    localparam int PMC_BIT_SRC_LO = 5;
    localparam int PMC_BIT_IRQ_EN = 4;
    localparam int PMC_BIT_DIV_HI = 3;
    // reset values
    localparam logic [7:0] PMC_RST_BYTE = 8'h00;
    localparam logic [1:0] PMC_RST_SRC = 2'h0;
    localparam logic [3:0] PMC_RST_DIV = 4'h0;
    // source select encodings
    localparam logic [1:0] PMC_SRC_LOW_POWER_OSC = 2'h0;
    localparam logic [1:0] PMC_SRC_EXT = 2'h1;
    // prescaler divide counter width (2^18 > largest divide of 200000)
    localparam int PMC_PS_W = 18;
    // interrupt status bit: match event
    localparam int PMC_EV_MATCH = 0;

    // control fields of status_control
    typedef struct packed {
        logic [1:0] source_select;
        logic match_irq_enable;
        logic [3:0] divider_select;
    } pmc_ctrl_t;

    // source clock inputs, sampled as levels
    typedef struct packed {
        logic low_power_osc;
        logic external_ref_clock;
        logic internal_ref_clock;
    } pmc_src_t;
endpackage

// File: design/pmc_counter.sv
// periodic match counter: prescaler, 8-bit counter, apb registers
`timescale 1ns/1ns
module pmc_counter
    import pmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pmc_src_t src_clk,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // divide value lookup
    function automatic logic [PMC_PS_W-1:0] div_value(
        input logic bit0,
        input logic [3:0] sel
    );
        logic [PMC_PS_W-1:0] v;
        v = '0;
        case ({bit0, sel})
            5'h01: v = 18'h00008;
            5'h02: v = 18'h00020;
            5'h03: v = 18'h00040;
            5'h04: v = 18'h00080;
            5'h05: v = 18'h00100;
            5'h06: v = 18'h00200;
            5'h07: v = 18'h00400;
            5'h08: v = 18'h00001;
            5'h09: v = 18'h00002;
            5'h0A: v = 18'h00004;
            5'h0B: v = 18'h0000A;
            5'h0C: v = 18'h00010;
            5'h0D: v = 18'h00064;
            5'h0E: v = 18'h001F4;
            5'h0F: v = 18'h003E8;
            5'h11: v = 18'h00400;
            5'h12: v = 18'h00800;
            5'h13: v = 18'h01000;
            5'h14: v = 18'h02000;
            5'h15: v = 18'h04000;
            5'h16: v = 18'h08000;
            5'h17: v = 18'h10000;
            5'h18: v = 18'h003E8;
            5'h19: v = 18'h007D0;
            5'h1A: v = 18'h01388;
            5'h1B: v = 18'h02710;
            5'h1C: v = 18'h04E20;
            5'h1D: v = 18'h0C350;
            5'h1E: v = 18'h186A0;
            5'h1F: v = 18'h30D40;
            default: v = '0;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // source synchronisers and edge detect
    logic [2:0] sync1_reg, sync2_reg, sync3_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end
        else
        begin
            sync1_reg <= src_clk;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    logic [2:0] src_rise;
    assign src_rise = sync2_reg & ~sync3_reg;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    logic wr_en, rd_en, addr_ok;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign addr_ok = paddr[31:0] == {24'h000000, PMC_OFS_STATUS_CONTROL}
        || paddr[31:0] == {24'h000000, PMC_OFS_COUNT_VALUE}
        || paddr[31:0] == {24'h000000, PMC_OFS_MATCH_LIMIT}
        || paddr[31:0] == {24'h000000, PMC_OFS_IRQ_STATUS}
        || paddr[31:0] == {24'h000000, PMC_OFS_IRQ_MASK};
    assign pslverr = psel && penable && !addr_ok;

    logic wr_sc, wr_lim, wr_ist, wr_msk;
    assign wr_sc = wr_en && paddr == {24'h000000, PMC_OFS_STATUS_CONTROL};
    assign wr_lim = wr_en && paddr == {24'h000000, PMC_OFS_MATCH_LIMIT};
    assign wr_ist = wr_en && paddr == {24'h000000, PMC_OFS_IRQ_STATUS};
    assign wr_msk = wr_en && paddr == {24'h000000, PMC_OFS_IRQ_MASK};

    ////////////////////////////////////////////////////////////////////////
    // state
    pmc_ctrl_t ctrl_reg, ctrl_next;
    logic flag_reg, flag_next;
    logic [7:0] limit_reg, limit_next;
    logic [7:0] count_reg, count_next;
    logic [PMC_PS_W-1:0] ps_reg, ps_next;
    logic mask_reg, mask_next;
    logic tick, src_edge, restart;
    logic [PMC_PS_W-1:0] div;

    always_comb
    begin
        ctrl_next = ctrl_reg;
        flag_next = flag_reg;
        limit_next = limit_reg;
        count_next = count_reg;
        ps_next = ps_reg;
        mask_next = mask_reg;
        restart = 1'b0;
        tick = 1'b0;
        div = div_value(ctrl_reg.source_select[0], ctrl_reg.divider_select);
        // source mux: 00 low power osc, 01 external, 1x internal
        case (ctrl_reg.source_select)
            PMC_SRC_LOW_POWER_OSC: src_edge = src_rise[2];
            PMC_SRC_EXT: src_edge = src_rise[1];
            default: src_edge = src_rise[0];
        endcase
        // prescaler off while divider select is zero
        if (ctrl_reg.divider_select != PMC_RST_DIV && src_edge)
        begin
            if (ps_reg >= div - 18'h00001)
            begin
                ps_next = '0;
                tick = 1'b1;
            end
            else
                ps_next = ps_reg + 18'h00001;
        end
        if (tick)
        begin
            if (count_reg == limit_reg)
            begin
                count_next = PMC_RST_BYTE;
                flag_next = 1'b1;
            end
            else
                count_next = count_reg + 8'h01;
        end
        if (wr_sc)
        begin
            ctrl_next.source_select = pwdata[PMC_BIT_SRC_HI:PMC_BIT_SRC_LO];
            ctrl_next.match_irq_enable = pwdata[PMC_BIT_IRQ_EN];
            ctrl_next.divider_select = pwdata[PMC_BIT_DIV_HI:0];
            if (ctrl_next.source_select != ctrl_reg.source_select)
                restart = 1'b1;
            if (ctrl_next.divider_select != ctrl_reg.divider_select)
                restart = 1'b1;
            // set wins over the clear in the same cycle
            if (pwdata[PMC_BIT_FLAG] && !(tick && count_reg == limit_reg))
                flag_next = 1'b0;
        end
        if (wr_ist && pwdata[PMC_EV_MATCH] && !(tick && count_reg == limit_reg))
            flag_next = 1'b0;
        if (wr_msk)
            mask_next = pwdata[PMC_EV_MATCH];
        if (wr_lim)
        begin
            limit_next = pwdata[7:0];
            restart = 1'b1;
        end
        if (restart)
        begin
            ps_next = '0;
            count_next = PMC_RST_BYTE;
        end
        // count register write falls through
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= '{PMC_RST_SRC, 1'b0, PMC_RST_DIV};
            flag_reg <= 1'b0;
            limit_reg <= PMC_RST_BYTE;
            count_reg <= PMC_RST_BYTE;
            ps_reg <= '0;
            mask_reg <= 1'b1;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            flag_reg <= flag_next;
            limit_reg <= limit_next;
            count_reg <= count_next;
            ps_reg <= ps_next;
            mask_reg <= mask_next;
        end
    end

    // read data muxes the registers; zero wait, valid in the access phase
    always_comb
    begin
        prdata = '0;
        if (rd_en)
        begin
            case (paddr[7:0])
                PMC_OFS_STATUS_CONTROL: prdata[7:0] = {flag_reg, ctrl_reg};
                PMC_OFS_COUNT_VALUE: prdata[7:0] = count_reg;
                PMC_OFS_MATCH_LIMIT: prdata[7:0] = limit_reg;
                PMC_OFS_IRQ_STATUS: prdata[PMC_EV_MATCH] = flag_reg;
                PMC_OFS_IRQ_MASK: prdata[PMC_EV_MATCH] = mask_reg;
                default: prdata = '0;
            endcase
        end
    end

    assign irq = flag_reg && ctrl_reg.match_irq_enable && mask_reg;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_flag_on_wrap: assert property (@(posedge pclk)
        disable iff (!presetn)
        (tick && count_reg == limit_reg && !wr_lim && !restart)
        |=> flag_reg && count_reg == PMC_RST_BYTE)
        else $error("match did not wrap count and set flag");
    a_flag_clear: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr_sc && pwdata[PMC_BIT_FLAG] && !tick) |=> !flag_reg)
        else $error("flag not cleared by write one");
    a_flag_keep: assert property (@(posedge pclk)
        disable iff (!presetn)
        (flag_reg && !wr_sc && !wr_ist) |=> flag_reg)
        else $error("flag lost without clear");
    a_ist_clear: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr_ist && pwdata[PMC_EV_MATCH] && !tick) |=> !flag_reg)
        else $error("flag not cleared through status write");
    a_irq_level: assert property (@(posedge pclk)
        disable iff (!presetn)
        irq == (flag_reg && ctrl_reg.match_irq_enable && mask_reg))
        else $error("irq does not follow flag and enable");
    a_irq_drop: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr_sc && !pwdata[PMC_BIT_IRQ_EN]) |=> !irq)
        else $error("irq stayed high with enable cleared");
    a_limit_clear: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_lim |=> count_reg == PMC_RST_BYTE && ps_reg == '0)
        else $error("limit write did not clear counters");
    a_src_change: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr_sc && pwdata[PMC_BIT_SRC_HI:PMC_BIT_SRC_LO]
            != ctrl_reg.source_select)
        |=> count_reg == PMC_RST_BYTE && ps_reg == '0)
        else $error("source change did not clear counters");
    a_div_change: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr_sc && pwdata[PMC_BIT_DIV_HI:0] != ctrl_reg.divider_select)
        |=> count_reg == PMC_RST_BYTE && ps_reg == '0)
        else $error("divider change did not clear counters");
    a_div_off: assert property (@(posedge pclk)
        disable iff (!presetn)
        (ctrl_reg.divider_select == PMC_RST_DIV) |-> !tick)
        else $error("tick while prescaler off");
    a_count_step: assert property (@(posedge pclk)
        disable iff (!presetn)
        (!tick && !restart) |=> $stable(count_reg))
        else $error("count moved without tick");
    a_count_inc: assert property (@(posedge pclk)
        disable iff (!presetn)
        (tick && !restart && count_reg != limit_reg)
        |=> count_reg == $past(count_reg) + 8'h01)
        else $error("count did not step on tick");
    a_tick_single: assert property (@(posedge pclk)
        disable iff (!presetn)
        tick |=> !tick)
        else $error("prescaler tick longer than one cycle");
    a_zero_limit: assert property (@(posedge pclk)
        disable iff (!presetn)
        (tick && limit_reg == PMC_RST_BYTE) |=> flag_reg)
        else $error("zero limit tick did not set flag");
    a_cnt_ro: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr_en && paddr[7:0] == PMC_OFS_COUNT_VALUE && !tick)
        |=> $stable(count_reg))
        else $error("count changed by write");

    ////////////////////////////////////////////////////////////////////////
    // cover points for the main scenarios
    c_match: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(flag_reg));
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_lim_zero: cover property (@(posedge pclk) disable iff (!presetn)
        tick && limit_reg == PMC_RST_BYTE);
    c_decimal: cover property (@(posedge pclk) disable iff (!presetn)
        tick && ctrl_reg.source_select[0] && ctrl_reg.divider_select[3]);
    c_restart: cover property (@(posedge pclk) disable iff (!presetn)
        wr_sc && restart);

endmodule

// File: verification/pmc_counter_tb_top.sv
// self-checking testbench for the periodic match counter
`timescale 1ns/1ns
module pmc_counter_tb_top;
    import pmc_pkg::*;
    typedef struct packed
    {
        logic [31:0] data;
        logic err;
        logic rd;
    } pmc_note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0] paddr, pwdata, prdata, r;
    pmc_src_t src_clk;
    pmc_note_t notes[$];
    pmc_note_t cur;
    int failures, compares, cycles;
    integer seed;

    pmc_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_clk(src_clk), .irq(irq));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic results;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic miss(input string m);
        failures++;
        $display("MISMATCH t=%0t %s", $time, m);
    endtask

    task automatic cmp_bus(input pmc_note_t n);
        compares++;
        if (pslverr !== n.err || (n.rd && !n.err && prdata !== n.data))
            miss("bus result");
    endtask

    ////////////////////////////////////////////////////////////////////
    // the oldest note is compared when a transfer completes
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            miss("timeout");
            results();
        end
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            cur = notes.pop_front();
            cmp_bus(cur);
        end
    end

    task automatic chk_irq(input logic e);
        @(negedge pclk);
        compares++;
        if (irq !== e)
            miss("irq level");
        @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////
    // apb master
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] e, input logic er);
        notes.push_back('{e, er, !w});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 1'b0);
    endtask

    // n rising edges on one source, random levels on the others
    task automatic pulse(input int idx, input int n);
        pmc_src_t s;
        repeat (n)
        begin
            r = $random(seed);
            s = r[2:0];
            s[idx] = 1'b1;
            src_clk <= s;
            repeat (2) @(posedge pclk);
            s[idx] = 1'b0;
            src_clk <= s;
            repeat (2) @(posedge pclk);
        end
        src_clk <= 3'h0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic run_case(input logic [1:0] sc, input logic [3:0] dv,
        input logic [7:0] lim, input int n, input logic [7:0] cnt,
        input logic fl);
        wr(PMC_OFS_STATUS_CONTROL, {24'h0, 1'b1, sc, 1'b1, dv});
        wr(PMC_OFS_MATCH_LIMIT, {24'h0, lim});
        pulse(sc == 2'h0 ? 2 : (sc == 2'h1 ? 1 : 0), n);
        rd(PMC_OFS_COUNT_VALUE, {24'h0, cnt});
        rd(PMC_OFS_STATUS_CONTROL, {24'h0, fl, sc, 1'b1, dv});
        chk_irq(fl);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        src_clk = 3'h0;
        seed = 32'h17E07DA9;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_irq(1'b0);
        rd(PMC_OFS_STATUS_CONTROL, 32'h0);
        rd(PMC_OFS_COUNT_VALUE, 32'h0);
        rd(PMC_OFS_MATCH_LIMIT, 32'h0);
        rd(PMC_OFS_IRQ_STATUS, 32'h0);
        rd(PMC_OFS_IRQ_MASK, 32'h1);
        r = $random(seed);
        wr(PMC_OFS_MATCH_LIMIT, r);
        rd(PMC_OFS_MATCH_LIMIT, {24'h0, r[7:0]});
        apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h20, r, 32'h0, 1'b1);
        run_case(2'h0, 4'h8, 8'h03, 6, 8'h02, 1'b1);
        run_case(2'h0, 4'h9, 8'h04, 6, 8'h03, 1'b0);
        run_case(2'h0, 4'h1, 8'h00, 8, 8'h00, 1'b1);
        run_case(2'h0, 4'hB, 8'h01, 20, 8'h00, 1'b1);
        run_case(2'h1, 4'h0, 8'h00, 5, 8'h00, 1'b0);
        run_case(2'h1, 4'h8, 8'h05, 2000, 8'h02, 1'b0);
        run_case(2'h1, 4'h1, 8'h00, 1024, 8'h00, 1'b1);
        run_case(2'h2, 4'hA, 8'h02, 12, 8'h00, 1'b1);
        run_case(2'h3, 4'h8, 8'h00, 1000, 8'h00, 1'b1);
        wr(PMC_OFS_STATUS_CONTROL, 32'h78);
        rd(PMC_OFS_STATUS_CONTROL, 32'hF8);
        wr(PMC_OFS_IRQ_MASK, 32'h0);
        chk_irq(1'b0);
        rd(PMC_OFS_IRQ_STATUS, 32'h1);
        wr(PMC_OFS_IRQ_MASK, 32'h1);
        chk_irq(1'b1);
        wr(PMC_OFS_IRQ_STATUS, 32'h1);
        chk_irq(1'b0);
        rd(PMC_OFS_STATUS_CONTROL, 32'h78);
        for (int k = 0; k < 3; k++)
        begin
            run_case(2'h0, 4'h8, 8'h03, 6, 8'h02, 1'b1);
            if (k == 0)
            begin
                wr(PMC_OFS_COUNT_VALUE, 32'hFF);
                rd(PMC_OFS_COUNT_VALUE, 32'h2);
                wr(PMC_OFS_STATUS_CONTROL, 32'h08);
                chk_irq(1'b0);
                rd(PMC_OFS_STATUS_CONTROL, 32'h88);
                wr(PMC_OFS_STATUS_CONTROL, 32'h38);
            end
            else if (k == 1)
                wr(PMC_OFS_STATUS_CONTROL, 32'h19);
            else
                wr(PMC_OFS_MATCH_LIMIT, 32'h3);
            rd(PMC_OFS_COUNT_VALUE, 32'h0);
        end
        // reset in mid-run with flag, count and limit all nonzero
        run_case(2'h2, 4'h9, 8'h01, 6, 8'h01, 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_irq(1'b0);
        rd(PMC_OFS_STATUS_CONTROL, 32'h0);
        rd(PMC_OFS_MATCH_LIMIT, 32'h0);
        rd(PMC_OFS_COUNT_VALUE, 32'h0);
        rd(PMC_OFS_IRQ_MASK, 32'h1);
        results();
    end
endmodule
